// ===== core/lpt_pkg.sv
// Constants, types and register map for the threshold interrupt block
package lpt_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register offsets
    localparam logic [7:0] ADDR_PERSIST = 8'h43;
    localparam logic [7:0] ADDR_INT_CTRL = 8'h4a;
    localparam logic [7:0] ADDR_PROXIMITY_HIGH_THRESHOLD_L = 8'h4b;
    localparam logic [7:0] ADDR_PROXIMITY_HIGH_THRESHOLD_M = 8'h4c;
    localparam logic [7:0] ADDR_PROXIMITY_LOW_THRESHOLD_L = 8'h4d;
    localparam logic [7:0] ADDR_PROXIMITY_LOW_THRESHOLD_M = 8'h4e;
    localparam logic [7:0] ADDR_ALS_TH_L = 8'h4f;
    localparam logic [7:0] ADDR_ALS_TH_M = 8'h50;
    localparam logic [7:0] ADDR_ALS_TL_L = 8'h51;
    localparam logic [7:0] ADDR_ALS_TL_M = 8'h52;

    ////////////////////////////////////////////////////////////////////////
    // Interrupt control fields
    localparam int CTRL_PS_STAT_BIT = 7;
    localparam int CTRL_ALS_STAT_BIT = 6;
    localparam int CTRL_MODE_HI = 5;
    localparam int CTRL_MODE_LO = 4;
    localparam int CTRL_LATCH_BIT = 3;
    localparam int CTRL_CLR_BIT = 2;
    localparam int CTRL_ALS_EN_BIT = 1;
    localparam int CTRL_PS_EN_BIT = 0;
    localparam int PERSIST_HI = 3;

    ////////////////////////////////////////////////////////////////////////
    // Proximity modes
    localparam logic [1:0] PM_HIGH_ONLY = 2'h0;
    localparam logic [1:0] PM_HYST = 2'h1;
    localparam logic [1:0] PM_OUTSIDE = 2'h2;
    localparam logic [1:0] PM_RESERVED = 2'h3;

    ////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic [7:0] RST_CTRL = 8'h00;
    localparam logic [3:0] RST_PERSIST = 4'h0;
    localparam logic [11:0] RST_PS_HI = 12'hfff;
    localparam logic [11:0] RST_PS_LO = 12'h000;
    localparam logic [15:0] RST_ALS_HI = 16'hffff;
    localparam logic [15:0] RST_ALS_LO = 16'h0000;
    localparam logic [7:0] RDATA_NONE = 8'h00;

    ////////////////////////////////////////////////////////////////////////
    // Types
    typedef enum logic {PX_INACTIVE, PX_ACTIVE} lpt_px_state_t;

    typedef struct packed {
        logic [11:0] ps_hi;
        logic [11:0] ps_lo;
        logic [15:0] als_hi;
        logic [15:0] als_lo;
    } lpt_thr_t;

endpackage

// ===== core/lpt_prox_eval.sv
// Proximity comparator with mode select, hysteresis and persistence
`timescale 1ns/1ps
module lpt_prox_eval import lpt_pkg::*; (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    input wire logic flush,
    // Result and settings
    input wire logic valid,
    input wire logic [11:0] result,
    input wire logic [11:0] hi,
    input wire logic [11:0] lo,
    input wire logic [1:0] mode,
    input wire logic [3:0] persist,
    // State
    output lpt_px_state_t state,
    output logic update
);

    lpt_px_state_t state_r, state_nxt, want;
    logic [3:0] cnt_r, cnt_nxt;
    logic upd_r, upd_nxt;

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        want = state_r;
        case (mode)
            PM_HIGH_ONLY: begin
                want = (result >= hi) ? PX_ACTIVE : PX_INACTIVE; // [RQ6] [RQ7]
            end
            PM_HYST: begin
                if (result > hi) begin
                    want = PX_ACTIVE; // [RQ8]
                end else if (result < lo) begin
                    want = PX_INACTIVE; // [RQ9]
                end else begin
                    want = state_r; // [RQ10]
                end
            end
            PM_OUTSIDE: begin
                want = ((result < lo) || (result > hi)) ? // [RQ11] [RQ12]
                    PX_ACTIVE : PX_INACTIVE;
            end
            default: begin
                want = PX_INACTIVE; // [RQ18]
            end
        endcase
    end

    // Persistence: a change needs that many results in a row; 0 acts as 1
    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        upd_nxt = 1'b0;
        if (flush) begin
            state_nxt = PX_INACTIVE;
            cnt_nxt = 4'h0;
        end else if (valid) begin // [RQ17]
            upd_nxt = 1'b1;
            if (mode == PM_RESERVED) begin
                state_nxt = PX_INACTIVE; // [RQ18]
                cnt_nxt = 4'h0;
            end else if (want == state_r) begin
                cnt_nxt = 4'h0;
            end else if ((cnt_r + 4'h1) >= persist) begin // [RQ16]
                state_nxt = want;
                cnt_nxt = 4'h0;
            end else begin
                cnt_nxt = cnt_r + 4'h1;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_r <= PX_INACTIVE;
            cnt_r <= 4'h0;
            upd_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            upd_r <= upd_nxt;
        end
    end

    assign state = state_r;
    assign update = upd_r;

endmodule // lpt_prox_eval

// ===== core/lpt_irq.sv
// Light and proximity threshold interrupt logic with its registers
//
// Operation
// [RQ1] Light interrupt active when visible result is above high or below low.
// [RQ2] Light interrupt inactive while visible result lies inside the window.
// [RQ3] Light comparison is a fixed window; no setting alters it.
// [RQ4] Light thresholds are compared only with visible-channel results.
// [RQ5] Proximity mode comes from bits 5:4 of interrupt control.
// [RQ6] Mode 00: active when proximity result is at or above high threshold.
// [RQ7] Mode 00: inactive when result is below high; low threshold ignored.
// [RQ8] Mode 01: switch active when result exceeds high threshold.
// [RQ9] Mode 01: switch inactive when result drops below low threshold.
// [RQ10] Mode 01: results between thresholds keep the current state.
// [RQ11] Mode 10: active when result lies outside low..high range.
// [RQ12] Mode 10: inactive while result lies within low..high range.
// [RQ13] Latched: asserted status clears only by reset command or status read.
// [RQ14] Status clears by command, status read or soft reset; standby holds.
// [RQ15] Interrupt pin is open drain, pulled low when active, released at reset.
// [RQ16] Persistence count filters proximity comparisons only, never light.
// [RQ17] Comparisons are evaluated once per completed measurement.
// [RQ18] Mode 11 is reserved and keeps the proximity state inactive.
`timescale 1ns/1ps
module lpt_irq import lpt_pkg::*; (
    // Clock and reset
    input wire logic CLK,
    input wire logic RESET,
    input wire logic SW_RESET,
    // Register port from the serial front end
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [7:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    output logic [7:0] REG_RDATA,
    // Measurement results
    input wire logic ALS_VALID,
    input wire logic [15:0] VISIBLE_LIGHT_CHANNEL,
    input wire logic PS_VALID,
    input wire logic [11:0] PROXIMITY_SENSING,
    // Open-drain interrupt pin
    output logic INT_O,
    output logic INT_OE,
    // Status
    output logic PS_STATUS,
    output logic ALS_STATUS
);

    ////////////////////////////////////////////////////////////////////////
    // Declarations
    lpt_thr_t thr_r, thr_nxt;
    logic [1:0] mode_r, mode_nxt;
    logic latch_r, latch_nxt;
    logic als_en_r, als_en_nxt;
    logic ps_en_r, ps_en_nxt;
    logic [3:0] persist_r, persist_nxt;
    logic ps_stat_r, ps_stat_nxt;
    logic als_stat_r, als_stat_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    logic oe_r, oe_nxt;
    logic int_o_r;
    logic clr;
    logic als_hit;
    lpt_px_state_t px_state;
    logic px_update;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
        hit = (a == b);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Proximity comparator
    lpt_prox_eval u_prox (
        .clk(CLK),
        .rst(RESET),
        .flush(SW_RESET),
        .valid(PS_VALID),
        .result(PROXIMITY_SENSING),
        .hi(thr_r.ps_hi),
        .lo(thr_r.ps_lo),
        .mode(mode_r), // [RQ5]
        .persist(persist_r), // [RQ16]
        .state(px_state),
        .update(px_update)
    );

    ////////////////////////////////////////////////////////////////////////
    // Light window, unfiltered and fixed
    assign als_hit = (VISIBLE_LIGHT_CHANNEL > thr_r.als_hi) || // [RQ1] [RQ3]
        (VISIBLE_LIGHT_CHANNEL < thr_r.als_lo); // [RQ4]

    // Clear sources; a read clears after the read data is captured
    assign clr = (REG_RD && hit(REG_ADDR, ADDR_INT_CTRL)) || // [RQ14]
        (REG_WR && hit(REG_ADDR, ADDR_INT_CTRL) && REG_WDATA[CTRL_CLR_BIT]);

    ////////////////////////////////////////////////////////////////////////
    // Configuration registers
    always_comb begin
        thr_nxt = thr_r;
        mode_nxt = mode_r;
        latch_nxt = latch_r;
        als_en_nxt = als_en_r;
        ps_en_nxt = ps_en_r;
        persist_nxt = persist_r;
        if (SW_RESET) begin
            thr_nxt = '{RST_PS_HI, RST_PS_LO, RST_ALS_HI, RST_ALS_LO};
            mode_nxt = RST_CTRL[CTRL_MODE_HI:CTRL_MODE_LO];
            latch_nxt = RST_CTRL[CTRL_LATCH_BIT];
            als_en_nxt = RST_CTRL[CTRL_ALS_EN_BIT];
            ps_en_nxt = RST_CTRL[CTRL_PS_EN_BIT];
            persist_nxt = RST_PERSIST;
        end else if (REG_WR) begin
            case (REG_ADDR)
                ADDR_PERSIST: begin
                    persist_nxt = REG_WDATA[PERSIST_HI:0];
                end
                ADDR_INT_CTRL: begin
                    mode_nxt = REG_WDATA[CTRL_MODE_HI:CTRL_MODE_LO]; // [RQ5]
                    latch_nxt = REG_WDATA[CTRL_LATCH_BIT];
                    als_en_nxt = REG_WDATA[CTRL_ALS_EN_BIT];
                    ps_en_nxt = REG_WDATA[CTRL_PS_EN_BIT];
                end
                ADDR_PROXIMITY_HIGH_THRESHOLD_L: thr_nxt.ps_hi[7:0] = REG_WDATA;
                ADDR_PROXIMITY_HIGH_THRESHOLD_M: thr_nxt.ps_hi[11:8] = REG_WDATA[3:0];
                ADDR_PROXIMITY_LOW_THRESHOLD_L: thr_nxt.ps_lo[7:0] = REG_WDATA;
                ADDR_PROXIMITY_LOW_THRESHOLD_M: thr_nxt.ps_lo[11:8] = REG_WDATA[3:0];
                ADDR_ALS_TH_L: thr_nxt.als_hi[7:0] = REG_WDATA;
                ADDR_ALS_TH_M: thr_nxt.als_hi[15:8] = REG_WDATA;
                ADDR_ALS_TL_L: thr_nxt.als_lo[7:0] = REG_WDATA;
                ADDR_ALS_TL_M: thr_nxt.als_lo[15:8] = REG_WDATA;
                default: begin
                    thr_nxt = thr_r;
                end
            endcase
        end
    end

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            thr_r <= '{RST_PS_HI, RST_PS_LO, RST_ALS_HI, RST_ALS_LO};
            mode_r <= RST_CTRL[CTRL_MODE_HI:CTRL_MODE_LO];
            latch_r <= RST_CTRL[CTRL_LATCH_BIT];
            als_en_r <= RST_CTRL[CTRL_ALS_EN_BIT];
            ps_en_r <= RST_CTRL[CTRL_PS_EN_BIT];
            persist_r <= RST_PERSIST;
        end else begin
            thr_r <= thr_nxt;
            mode_r <= mode_nxt;
            latch_r <= latch_nxt;
            als_en_r <= als_en_nxt;
            ps_en_r <= ps_en_nxt;
            persist_r <= persist_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Status; a new hit in the clearing cycle wins over the clear
    // No standby input: status only moves on results or clears
    always_comb begin
        als_stat_nxt = als_stat_r;
        ps_stat_nxt = ps_stat_r;
        if (SW_RESET) begin
            als_stat_nxt = 1'b0; // [RQ14]
            ps_stat_nxt = 1'b0;
        end else begin
            if (clr) begin
                als_stat_nxt = 1'b0; // [RQ14]
                ps_stat_nxt = 1'b0;
            end
            if (ALS_VALID) begin // [RQ17]
                if (latch_r) begin
                    als_stat_nxt = als_stat_nxt | als_hit; // [RQ13]
                end else begin
                    als_stat_nxt = als_hit; // [RQ1] [RQ2]
                end
            end
            if (px_update) begin // [RQ17]
                if (latch_r) begin
                    ps_stat_nxt = ps_stat_nxt | // [RQ13]
                        (px_state == PX_ACTIVE);
                end else begin
                    ps_stat_nxt = (px_state == PX_ACTIVE);
                end
            end
        end
        oe_nxt = (ps_stat_nxt && ps_en_r) || (als_stat_nxt && als_en_r);
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data, registered; unmapped offsets read zero
    // Soft reset empties the read register as a power-up would
    always_comb begin
        rdata_nxt = rdata_r;
        if (SW_RESET) begin
            rdata_nxt = RDATA_NONE; // [RQ14]
        end else if (REG_RD) begin
            case (REG_ADDR)
                ADDR_PERSIST: rdata_nxt = {4'h0, persist_r};
                ADDR_INT_CTRL: begin
                    rdata_nxt = {ps_stat_r, als_stat_r, mode_r, latch_r,
                        1'b0, als_en_r, ps_en_r};
                end
                ADDR_PROXIMITY_HIGH_THRESHOLD_L: rdata_nxt = thr_r.ps_hi[7:0];
                ADDR_PROXIMITY_HIGH_THRESHOLD_M: rdata_nxt = {4'h0, thr_r.ps_hi[11:8]};
                ADDR_PROXIMITY_LOW_THRESHOLD_L: rdata_nxt = thr_r.ps_lo[7:0];
                ADDR_PROXIMITY_LOW_THRESHOLD_M: rdata_nxt = {4'h0, thr_r.ps_lo[11:8]};
                ADDR_ALS_TH_L: rdata_nxt = thr_r.als_hi[7:0];
                ADDR_ALS_TH_M: rdata_nxt = thr_r.als_hi[15:8];
                ADDR_ALS_TL_L: rdata_nxt = thr_r.als_lo[7:0];
                ADDR_ALS_TL_M: rdata_nxt = thr_r.als_lo[15:8];
                default: rdata_nxt = RDATA_NONE;
            endcase
        end
    end

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            als_stat_r <= 1'b0;
            ps_stat_r <= 1'b0;
            oe_r <= 1'b0; // [RQ15]
            int_o_r <= 1'b0;
            rdata_r <= RDATA_NONE;
        end else begin
            als_stat_r <= als_stat_nxt;
            ps_stat_r <= ps_stat_nxt;
            oe_r <= oe_nxt; // [RQ15]
            int_o_r <= 1'b0; // Only ever pulls low
            rdata_r <= rdata_nxt;
        end
    end

    assign INT_O = int_o_r;
    assign INT_OE = oe_r;
    assign REG_RDATA = rdata_r;
    assign PS_STATUS = ps_stat_r;
    assign ALS_STATUS = als_stat_r;

endmodule // lpt_irq

// ===== dv/lpt_int_pullup.sv
// Board pull-up model resolving the open-drain interrupt line
`timescale 1ns/1ps
module lpt_int_pullup (
    // Pin drive from the device
    input wire logic oe,
    input wire logic o,
    // Line level seen by the host
    output wire logic line
);
    // Released line floats up through the resistor
    assign line = oe ? o : 1'b1;
endmodule // lpt_int_pullup

// ===== dv/lpt_irq_properties.sv
// Port-level assertions for the threshold interrupt block
`timescale 1ns/1ps
module lpt_irq_chk import lpt_pkg::*; (
    // Clock and reset
    input wire logic CLK,
    input wire logic RESET,
    input wire logic SW_RESET,
    // Register port
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [7:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic [7:0] REG_RDATA,
    // Results
    input wire logic ALS_VALID,
    input wire logic [15:0] VISIBLE_LIGHT_CHANNEL,
    input wire logic PS_VALID,
    input wire logic [11:0] PROXIMITY_SENSING,
    // Pin and status
    input wire logic INT_O,
    input wire logic INT_OE,
    input wire logic PS_STATUS,
    input wire logic ALS_STATUS
);
    logic [7:0] ctrl_r;
    logic [7:0] ctrl_nxt;
    logic clr;
    default clocking @(posedge CLK); endclocking
    default disable iff (RESET);
    ////////////////////////////////////////////////////////////////////
    // Shadow of control bits, so pin and mode checks need no peeking
    always_comb begin
        ctrl_nxt = ctrl_r;
        if (SW_RESET)
            ctrl_nxt = RST_CTRL;
        else if (REG_WR && REG_ADDR == ADDR_INT_CTRL)
            ctrl_nxt = REG_WDATA;
    end
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET)
            ctrl_r <= RST_CTRL;
        else
            ctrl_r <= ctrl_nxt;
    end
    assign clr = REG_ADDR == ADDR_INT_CTRL
        && (REG_RD || REG_WR && REG_WDATA[CTRL_CLR_BIT]);
    sequence s_res_ps;
        PS_VALID && ctrl_r[5:4] == PM_RESERVED && !ctrl_r[CTRL_LATCH_BIT]
        ##1 ctrl_r[5:4] == PM_RESERVED && !ctrl_r[CTRL_LATCH_BIT];
    endsequence
    ////////////////////////////////////////////////////////////////////
    a_pin_never_high: assert property (INT_O == 1'b0)
        else $error("interrupt pin driven high");
    a_pin_follows_en: assert property (ctrl_r[1:0] == $past(ctrl_r[1:0])
        |-> INT_OE == (PS_STATUS && ctrl_r[0] || ALS_STATUS && ctrl_r[1]))
        else $error("pin enable disagrees with status");
    a_als_rise_cause: assert property ($rose(ALS_STATUS) |-> $past(ALS_VALID))
        else $error("light status rose without result");
    a_ps_rise_cause: assert property ($rose(PS_STATUS) |-> $past(PS_VALID, 2))
        else $error("prox status rose without result");
    a_clear_als: assert property (clr && !ALS_VALID |=> !ALS_STATUS)
        else $error("light status not cleared");
    a_clear_ps: assert property (clr && !$past(PS_VALID) |=> !PS_STATUS)
        else $error("prox status not cleared");
    a_soft_reset: assert property (SW_RESET |=> !PS_STATUS && !ALS_STATUS
        && !INT_OE && REG_RDATA == RDATA_NONE)
        else $error("soft reset left state");
    a_rdata_hold: assert property (!REG_RD && !SW_RESET |=> $stable(REG_RDATA))
        else $error("read data moved without read");
    a_ctrl_readback: assert property (REG_RD && REG_ADDR == ADDR_INT_CTRL
        && !SW_RESET |=> REG_RDATA == {$past(PS_STATUS), $past(ALS_STATUS),
        $past(ctrl_r[5:3]), 1'b0, $past(ctrl_r[1:0])})
        else $error("control readback wrong");
    a_reserved_mode: assert property (s_res_ps |=> !PS_STATUS)
        else $error("reserved mode raised prox status");
endmodule // lpt_irq_chk

bind lpt_irq lpt_irq_chk u_chk (.CLK(CLK), .RESET(RESET),
    .SW_RESET(SW_RESET), .REG_WR(REG_WR), .REG_RD(REG_RD),
    .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
    .ALS_VALID(ALS_VALID), .VISIBLE_LIGHT_CHANNEL(VISIBLE_LIGHT_CHANNEL),
    .PS_VALID(PS_VALID), .PROXIMITY_SENSING(PROXIMITY_SENSING),
    .INT_O(INT_O), .INT_OE(INT_OE), .PS_STATUS(PS_STATUS),
    .ALS_STATUS(ALS_STATUS));

// ===== dv/tb_light_proximity_threshold_irq.sv
// Register-level test of the threshold interrupt block
`timescale 1ns/1ps
module tb_light_proximity_threshold_irq import lpt_pkg::*;;
    logic clk = 1'b0, reset = 1'b1, sw_reset = 1'b0;
    logic wr = 1'b0, rd = 1'b0, als_v = 1'b0, ps_v = 1'b0;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
    logic [15:0] vis = 16'h0000;
    logic [11:0] prox = 12'h000;
    logic int_o, int_oe, ps_st, als_st;
    logic [1:0] m = 2'h3;
    wire int_line;
    int failures = 0, n_compared = 0, cycles = 0;
    // Prox table: [15] expected, [13:12] mode, [11:0] result
    logic [15:0] tbl [16] = '{16'h8200, 16'h01ff, 16'h0050, 16'h8300,
        16'h9201, 16'h9150, 16'h9200, 16'h10ff, 16'h1150, 16'h1200,
        16'ha0ff, 16'h2100, 16'h2200, 16'ha201, 16'h2150, 16'h3300};
    logic [16:0] lt [5] = '{17'h11001, 17'h01000, 17'h00100, 17'h100ff,
        17'h00800};
    logic [7:0] rst_a [11] = '{8'h43, 8'h4a, 8'h4b, 8'h4c, 8'h4d, 8'h4e,
        8'h4f, 8'h50, 8'h51, 8'h52, 8'h60};
    logic [7:0] rst_v [11] = '{8'h00, 8'h00, 8'hff, 8'h0f, 8'h00, 8'h00,
        8'hff, 8'hff, 8'h00, 8'h00, 8'h00};
    always #5 clk = ~clk;
    lpt_irq DUT (.CLK(clk), .RESET(reset), .SW_RESET(sw_reset),
        .REG_WR(wr), .REG_RD(rd), .REG_ADDR(addr), .REG_WDATA(wdata),
        .REG_RDATA(rdata), .ALS_VALID(als_v), .VISIBLE_LIGHT_CHANNEL(vis),
        .PS_VALID(ps_v), .PROXIMITY_SENSING(prox), .INT_O(int_o),
        .INT_OE(int_oe), .PS_STATUS(ps_st), .ALS_STATUS(als_st));
    lpt_int_pullup u_pull (.oe(int_oe), .o(int_o), .line(int_line));
    ////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr8(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(rdata, exp);
    endtask
    // Result pulse, then wait out the two-cycle proximity answer
    task automatic meas(input logic is_ps, input logic [15:0] v);
        @(posedge clk);
        ps_v <= is_ps;
        als_v <= !is_ps;
        prox <= v[11:0];
        vis <= v;
        @(posedge clk);
        ps_v <= 1'b0;
        als_v <= 1'b0;
        @(posedge clk);
        #1;
    endtask
    task automatic complete_run;
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            failures++;
            complete_run();
        end
    end
    ////////////////////////////////////////////////////////////////////
    initial begin
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        for (int i = 0; i < 11; i++)
            rd_chk(rst_a[i], rst_v[i]);
        chk({7'h0, int_line}, 8'h01);
        $display("test 1 done");
        wr8(ADDR_ALS_TH_L, 8'h00);
        wr8(ADDR_ALS_TH_M, 8'h10);
        wr8(ADDR_ALS_TL_L, 8'h00);
        wr8(ADDR_ALS_TL_M, 8'h01);
        wr8(ADDR_INT_CTRL, 8'h02);
        for (int i = 0; i < 5; i++) begin
            meas(1'b0, lt[i][15:0]);
            chk({7'h0, als_st}, {7'h0, lt[i][16]});
            chk({7'h0, int_line}, {7'h0, !lt[i][16]});
        end
        $display("test 2 done");
        wr8(ADDR_PROXIMITY_HIGH_THRESHOLD_M, 8'h02);
        wr8(ADDR_PROXIMITY_HIGH_THRESHOLD_L, 8'h00);
        wr8(ADDR_PROXIMITY_LOW_THRESHOLD_M, 8'h01);
        for (int i = 0; i < 16; i++) begin
            if (tbl[i][13:12] != m)
                wr8(ADDR_INT_CTRL, {2'h0, tbl[i][13:12], 4'h1});
            m = tbl[i][13:12];
            meas(1'b1, {4'h0, tbl[i][11:0]});
            chk({7'h0, ps_st}, {7'h0, tbl[i][15]});
            chk({7'h0, int_line}, {7'h0, !tbl[i][15]});
            chk({7'h0, als_st}, 8'h00);
        end
        $display("test 3 done");
        wr8(ADDR_INT_CTRL, 8'h09);
        meas(1'b1, 16'h0300);
        meas(1'b1, 16'h0000);
        chk({7'h0, ps_st}, 8'h01);
        rd_chk(ADDR_INT_CTRL, 8'h89);
        chk({7'h0, ps_st}, 8'h00);
        meas(1'b1, 16'h0300);
        wr8(ADDR_INT_CTRL, 8'h0d);
        chk({7'h0, ps_st}, 8'h00);
        rd_chk(ADDR_INT_CTRL, 8'h09);
        meas(1'b1, 16'h0300);
        repeat (20) @(posedge clk);
        #1;
        chk({7'h0, ps_st}, 8'h01);
        @(posedge clk);
        sw_reset <= 1'b1;
        @(posedge clk);
        sw_reset <= 1'b0;
        #1;
        chk({7'h0, ps_st}, 8'h00);
        rd_chk(ADDR_INT_CTRL, 8'h00);
        $display("test 4 done");
        wr8(ADDR_PERSIST, 8'h02);
        wr8(ADDR_ALS_TL_L, 8'h10);
        wr8(ADDR_INT_CTRL, 8'h03);
        meas(1'b1, 16'h0fff);
        chk({7'h0, ps_st}, 8'h00);
        meas(1'b1, 16'h0fff);
        chk({7'h0, ps_st}, 8'h01);
        meas(1'b0, 16'h0005);
        chk({7'h0, als_st}, 8'h01);
        chk({7'h0, int_line}, 8'h00);
        $display("test 5 done");
        complete_run();
    end
endmodule // tb_light_proximity_threshold_irq
